/* File: hdl/decode_pkg.sv */
/*
   Shared constants and types for the instruction decoder: format classes,
   field positions, extension widths, data-type codes and reset values.
   Assumes a 16-bit half-word instruction stream and 32-bit operands.
*/
package decode_pkg;

   // Format classes of the instruction stream.
   typedef enum logic [2:0] {FMT_RR, FMT_RIMM, FMT_CONST, FMT_DIS, FMT_LIM} fmt_t;

   // Major opcode values (bits 15..12) that select a format or behaviour.
   localparam logic [3:0] OP_SHIFT = 4'h8;
   localparam logic [3:0] OP_LOAD = 4'h9;
   localparam logic [3:0] OP_STORE = 4'hA;
   localparam logic [3:0] OP_INDEX = 4'hE;
   localparam logic [3:0] OP_CONST = 4'h6;
   localparam logic [3:0] OP_IMM = 4'h7;
   localparam logic [3:0] OP_CHECKED = 4'h5;
   localparam logic [3:0] OP_FRAME = 4'hF;

   // Bit positions in the first half-word.
   localparam int OP_HI = 15;
   localparam int OP_LO = 12;
   localparam int DBIT = 9;
   localparam int SBIT = 8;
   localparam int NBIT = 8;

   // Bit positions in the second half-word.
   localparam int EBIT = 15;
   localparam int SIGNBIT = 14;
   localparam int DT_HI = 13;
   localparam int DT_LO = 12;
   localparam int IX_HI = 14;
   localparam int IX_LO = 12;

   // Extension widths of constants, displacements and limits.
   localparam int CONST_SHORT_EXT = 18;
   localparam int CONST_LONG_EXT = 2;
   localparam int DIS_SHORT_EXT = 20;
   localparam int DIS_LONG_EXT = 4;

   // Immediate selectors that carry extra half-words.
   localparam logic [4:0] N_LONG = 5'h11;
   localparam logic [4:0] N_ZERO16 = 5'h12;
   localparam logic [4:0] N_ONES16 = 5'h13;

   // Data-type codes of memory transfers.
   localparam logic [1:0] DT_BYTE = 2'h0;
   localparam logic [1:0] DT_HALF = 2'h1;
   localparam logic [1:0] DT_WORD = 2'h2;
   localparam logic [1:0] DT_DOUBLE = 2'h3;

   // Frame length value zero stands for a full frame.
   localparam logic [4:0] FRAME_FULL = 5'h10;
   localparam int SHIFT_BITS = 5;

   // Flag positions in the flag vector.
   localparam int FLAG_V = 3;

   // Reset values.
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage

/* File: hdl/operand_extend.sv */
/*
   Operand extension unit: builds the sign-extended constant, the
   sign-extended displacement, the zero-extended limit and the short
   immediate selector from the fetched half-words.
   Assumes its inputs are stable within the decode cycle; purely combinational.
*/
`timescale 1ns/1ps
module operand_extend
   import decode_pkg::*;
(
   input wire logic [15:0] hw0,
   input wire logic [15:0] hw1,
   input wire logic [15:0] hw2,
   output logic [31:0] const_val,
   output logic [31:0] dis_val,
   output logic [31:0] lim_val,
   output logic [4:0] n_sel
);

   logic e;
   logic sgn;

   assign e = hw1[EBIT];
   assign sgn = hw1[SIGNBIT];

   // Constants carry their sign in front of one or both parts. [RQ15]
   assign const_val = e ? {{CONST_LONG_EXT{sgn}}, hw1[13:0], hw2} : {{CONST_SHORT_EXT{sgn}}, hw1[13:0]};

   // Displacements: the two data-type bits sit between sign and first part. [RQ16]
   assign dis_val = e ? {{DIS_LONG_EXT{sgn}}, hw1[11:0], hw2} : {{DIS_SHORT_EXT{sgn}}, hw1[11:0]};

   // Limits are unsigned and padded with zeros. [RQ20]
   assign lim_val = e ? {{DIS_LONG_EXT{1'b0}}, hw1[11:0], hw2} : {{DIS_SHORT_EXT{1'b0}}, hw1[11:0]};

   // Short immediate selector: bit 8 joined with bits 3..0. [RQ18]
   assign n_sel = {hw0[NBIT], hw0[3:0]};

endmodule

/* File: hdl/insn_decode.sv */
/*
   Two-stage instruction decoder: decode of one to three half-words from the
   instruction cache, register bank selection, operand extension, load-use
   interlock, flag register and frame-length check, with the execute stage
   held in output registers.
   Assumes the cache presents the half-words at fetch_pc_q on ic_hw0..2 with
   ic_count telling how many are valid, and that all inputs share mclk.
*/
// Functional notes
// RQ1: Shifts use five low bits; small stores partial.
// RQ2: Decode in stage one, execute in stage two.
// RQ3: Single-cycle register ops may share source, destination.
// RQ4: Source kept unless it is destination or load.
// RQ5: Flags set when condition true, cleared otherwise.
// RQ6: Flag-updating checked ops may trap Range Error.
// RQ7: Results and flags forward with no penalty.
// RQ8: Stall while a pending load register is used.
// RQ9: Frame length zero means sixteen; check locals.
// RQ10: Following register is named address plus one.
// RQ11: Double word: high word at lower address.
// RQ12: Accept one, two or three aligned half-words.
// RQ13: Source select bit picks global or local bank.
// RQ14: Destination select bit picks global or local.
// RQ15: Constants sign-extended by eighteen or two bits.
// RQ16: Displacements sign-extended by twenty or four bits.
// RQ17: Bits 13..12 give memory data type.
// RQ18: Immediate selector is bit 8 with 3..0.
// RQ19: Bits 14..12 select the index instruction.
// RQ20: Limits zero-extended by twenty or four bits.
// RQ21: Load's local source field names load target.
// RQ22: Issue only when all half-words are available.
`timescale 1ns/1ps
module insn_decode
   import decode_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [15:0] ic_hw0,
   input wire logic [15:0] ic_hw1,
   input wire logic [15:0] ic_hw2,
   input wire logic [1:0] ic_count,
   input wire logic exec_hold,
   input wire logic load_done,
   input wire logic flag_we,
   input wire logic [3:0] cond_in,
   input wire logic [3:0] frame_length_field,
   output logic [31:0] fetch_pc_q,
   output logic [1:0] consume_q,
   output logic stall_q,
   output logic exec_valid_q,
   output logic [2:0] exec_fmt_q,
   output logic [1:0] exec_len_q,
   output logic [4:0] exec_src_q,
   output logic [4:0] exec_src_next_q,
   output logic [4:0] exec_dst_q,
   output logic [4:0] exec_dst_next_q,
   output logic exec_src_used_q,
   output logic exec_dst_used_q,
   output logic exec_src_clobbered_q,
   output logic exec_same_ok_q,
   output logic [31:0] exec_operand_q,
   output logic [4:0] exec_n_q,
   output logic [1:0] exec_dtype_q,
   output logic [2:0] exec_index_q,
   output logic exec_is_load_q,
   output logic exec_is_store_q,
   output logic exec_double_q,
   output logic [31:0] exec_src_mask_q,
   output logic [3:0] exec_byte_en_q,
   output logic exec_range_chk_q,
   output logic frame_err_q,
   output logic [3:0] flags_q,
   output logic range_trap_q
);

   // Format of a major opcode; the map is deliberately coarse.
   function automatic fmt_t fmt_of(input logic [3:0] op);
      unique case (op)
         OP_LOAD, OP_STORE: fmt_of = FMT_DIS;
         OP_INDEX: fmt_of = FMT_LIM;
         OP_CONST: fmt_of = FMT_CONST;
         OP_IMM: fmt_of = FMT_RIMM;
         default: fmt_of = FMT_RR;
      endcase
   endfunction

   // True when a used local register lies at or beyond the frame.
   function automatic logic out_of_frame(input logic used, input logic [4:0] addr, input logic [4:0] fl);
      out_of_frame = used && addr[4] && ({1'b0, addr[3:0]} >= fl);
   endfunction

   logic [3:0] op;
   fmt_t fmt;
   logic ext;
   logic [1:0] len;
   logic [4:0] src;
   logic [4:0] dst;
   logic src_used;
   logic dst_used;
   logic is_load;
   logic is_store;
   logic [31:0] const_val;
   logic [31:0] dis_val;
   logic [31:0] lim_val;
   logic [4:0] n_sel;
   logic [31:0] operand;
   logic [4:0] fl_int;
   logic hazard;
   logic go;

   operand_extend u_ext
   (
      .hw0(ic_hw0),
      .hw1(ic_hw1),
      .hw2(ic_hw2),
      .const_val(const_val),
      .dis_val(dis_val),
      .lim_val(lim_val),
      .n_sel(n_sel)
   );

   // Field decode of the instruction at the head of the stream.
   always_comb
   begin
      op = ic_hw0[OP_HI:OP_LO];
      fmt = fmt_of(op);
      ext = ic_hw1[EBIT];
      is_load = (op == OP_LOAD);
      is_store = (op == OP_STORE);
      src = {ic_hw0[SBIT], ic_hw0[3:0]}; // [RQ13]
      dst = {ic_hw0[DBIT], ic_hw0[7:4]}; // [RQ14]
      src_used = 1'b1;
      dst_used = 1'b1;
      operand = 32'h0000_0000;
      len = 2'h1;
      unique case (fmt)
         FMT_RR:
         begin
            len = 2'h1;
         end
         FMT_RIMM:
         begin
            // Immediate forms have no source register; the selector shares bit 8.
            src_used = 1'b0;
            dst = {ic_hw0[DBIT], ic_hw0[7:4]};
            if (n_sel == N_LONG)
            begin
               len = 2'h3; // [RQ12]
            end
            else if (n_sel == N_ZERO16 || n_sel == N_ONES16)
            begin
               len = 2'h2;
            end
            else
            begin
               len = 2'h1;
            end
         end
         FMT_CONST:
         begin
            len = ext ? 2'h3 : 2'h2; // [RQ22]
            operand = const_val;
         end
         FMT_DIS:
         begin
            len = ext ? 2'h3 : 2'h2; // [RQ22]
            operand = dis_val;
            if (is_load)
            begin
               // The local source field names where the loaded word lands. [RQ21]
               src = dst;
               dst = {1'b1, ic_hw0[3:0]};
            end
         end
         FMT_LIM:
         begin
            len = ext ? 2'h3 : 2'h2; // [RQ22]
            operand = lim_val;
         end
      endcase
   end

   // Frame length zero stands for sixteen usable locals. [RQ9]
   assign fl_int = (frame_length_field == 4'h0) ? FRAME_FULL : {1'b0, frame_length_field};

   logic load_pend_q;
   logic load_pend_d;
   logic [4:0] load_reg_q;
   logic [4:0] load_reg_d;

   // Interlock only on a load still in flight; all else forwards freely. [RQ7] [RQ8]
   assign hazard = load_pend_q && ((src_used && src == load_reg_q) || (dst_used && dst == load_reg_q));
   assign go = !exec_hold && !hazard && (ic_count >= len); // [RQ22]

   // Load scoreboard; a new load issued as the old one returns wins.
   always_comb
   begin
      load_pend_d = load_pend_q;
      load_reg_d = load_reg_q;
      if (load_done)
      begin
         load_pend_d = 1'b0;
      end
      if (go && is_load)
      begin
         load_pend_d = 1'b1; // [RQ8]
         load_reg_d = dst;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         load_pend_q <= 1'b0;
         load_reg_q <= 5'h00;
      end
      else
      begin
         load_pend_q <= load_pend_d;
         load_reg_q <= load_reg_d;
      end
   end

   logic [31:0] fetch_pc_d;
   logic [1:0] consume_d;
   logic stall_d;

   // Fetch side: the program counter moves in whole half-words, so bit 0 stays clear.
   always_comb
   begin
      fetch_pc_d = go ? fetch_pc_q + {29'h0, len, 1'b0} : fetch_pc_q; // [RQ12]
      consume_d = go ? len : 2'h0;
      stall_d = hazard && !exec_hold;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         fetch_pc_q <= PC_RESET;
         consume_q <= 2'h0;
         stall_q <= 1'b0;
      end
      else
      begin
         fetch_pc_q <= fetch_pc_d;
         consume_q <= consume_d;
         stall_q <= stall_d;
      end
   end

   logic exec_valid_d;
   logic [2:0] exec_fmt_d;
   logic [1:0] exec_len_d;
   logic [4:0] exec_src_d;
   logic [4:0] exec_src_next_d;
   logic [4:0] exec_dst_d;
   logic [4:0] exec_dst_next_d;
   logic exec_src_used_d;
   logic exec_dst_used_d;
   logic exec_src_clobbered_d;
   logic exec_same_ok_d;
   logic [31:0] exec_operand_d;
   logic [4:0] exec_n_d;
   logic [1:0] exec_dtype_d;
   logic [2:0] exec_index_d;
   logic exec_is_load_d;
   logic exec_is_store_d;
   logic exec_double_d;
   logic [31:0] exec_src_mask_d;
   logic [3:0] exec_byte_en_d;
   logic exec_range_chk_d;
   logic frame_err_d;

   // Execute stage register: it holds under exec_hold, else takes the next decode. [RQ2]
   always_comb
   begin
      exec_valid_d = exec_hold ? exec_valid_q : go;
      exec_fmt_d = exec_fmt_q;
      exec_len_d = exec_len_q;
      exec_src_d = exec_src_q;
      exec_src_next_d = exec_src_next_q;
      exec_dst_d = exec_dst_q;
      exec_dst_next_d = exec_dst_next_q;
      exec_src_used_d = exec_src_used_q;
      exec_dst_used_d = exec_dst_used_q;
      exec_src_clobbered_d = exec_src_clobbered_q;
      exec_same_ok_d = exec_same_ok_q;
      exec_operand_d = exec_operand_q;
      exec_n_d = exec_n_q;
      exec_dtype_d = exec_dtype_q;
      exec_index_d = exec_index_q;
      exec_is_load_d = exec_is_load_q;
      exec_is_store_d = exec_is_store_q;
      exec_double_d = exec_double_q;
      exec_src_mask_d = exec_src_mask_q;
      exec_byte_en_d = exec_byte_en_q;
      exec_range_chk_d = exec_range_chk_q;
      frame_err_d = frame_err_q;
      if (go)
      begin
         exec_fmt_d = fmt;
         exec_len_d = len;
         exec_src_d = src;
         exec_dst_d = dst;
         // Pair partner and low word of a double sit one address higher. [RQ10] [RQ11]
         exec_src_next_d = {src[4], src[3:0] + 4'h1};
         exec_dst_next_d = {dst[4], dst[3:0] + 4'h1};
         exec_src_used_d = src_used;
         exec_dst_used_d = dst_used;
         // A source survives unless it is also written, or names a load target. [RQ4]
         exec_src_clobbered_d = is_load || (src_used && src == dst);
         // Read and write in the same cycle make aliasing harmless here only. [RQ3]
         exec_same_ok_d = (fmt == FMT_RR) && (len == 2'h1);
         exec_operand_d = operand;
         exec_n_d = n_sel; // [RQ18]
         exec_dtype_d = ic_hw1[DT_HI:DT_LO]; // [RQ17]
         exec_index_d = ic_hw1[IX_HI:IX_LO]; // [RQ19]
         exec_is_load_d = is_load;
         exec_is_store_d = is_store;
         exec_double_d = (fmt == FMT_DIS) && (ic_hw1[DT_HI:DT_LO] == DT_DOUBLE); // [RQ11]
         // Only the low five bits of a shift count matter. [RQ1]
         exec_src_mask_d = (op == OP_SHIFT) ? {{(32 - SHIFT_BITS){1'b0}}, {SHIFT_BITS{1'b1}}} : 32'hFFFF_FFFF;
         exec_byte_en_d = 4'hF;
         if (is_store && ic_hw1[DT_HI:DT_LO] == DT_BYTE)
         begin
            exec_byte_en_d = 4'h1; // [RQ1]
         end
         else if (is_store && ic_hw1[DT_HI:DT_LO] == DT_HALF)
         begin
            exec_byte_en_d = 4'h3; // [RQ1]
         end
         exec_range_chk_d = (op == OP_CHECKED);
         // Frame instructions (OP_FRAME) may reach past the frame. [RQ9]
         frame_err_d = (op != OP_FRAME) && (out_of_frame(src_used, src, fl_int) || out_of_frame(dst_used, dst, fl_int));
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         exec_valid_q <= 1'b0;
         exec_fmt_q <= 3'h0;
         exec_len_q <= 2'h0;
         exec_src_q <= 5'h00;
         exec_src_next_q <= 5'h00;
         exec_dst_q <= 5'h00;
         exec_dst_next_q <= 5'h00;
         exec_src_used_q <= 1'b0;
         exec_dst_used_q <= 1'b0;
         exec_src_clobbered_q <= 1'b0;
         exec_same_ok_q <= 1'b0;
         exec_operand_q <= 32'h0000_0000;
         exec_n_q <= 5'h00;
         exec_dtype_q <= 2'h0;
         exec_index_q <= 3'h0;
         exec_is_load_q <= 1'b0;
         exec_is_store_q <= 1'b0;
         exec_double_q <= 1'b0;
         exec_src_mask_q <= 32'hFFFF_FFFF;
         exec_byte_en_q <= 4'h0;
         exec_range_chk_q <= 1'b0;
         frame_err_q <= 1'b0;
      end
      else
      begin
         exec_valid_q <= exec_valid_d;
         exec_fmt_q <= exec_fmt_d;
         exec_len_q <= exec_len_d;
         exec_src_q <= exec_src_d;
         exec_src_next_q <= exec_src_next_d;
         exec_dst_q <= exec_dst_d;
         exec_dst_next_q <= exec_dst_next_d;
         exec_src_used_q <= exec_src_used_d;
         exec_dst_used_q <= exec_dst_used_d;
         exec_src_clobbered_q <= exec_src_clobbered_d;
         exec_same_ok_q <= exec_same_ok_d;
         exec_operand_q <= exec_operand_d;
         exec_n_q <= exec_n_d;
         exec_dtype_q <= exec_dtype_d;
         exec_index_q <= exec_index_d;
         exec_is_load_q <= exec_is_load_d;
         exec_is_store_q <= exec_is_store_d;
         exec_double_q <= exec_double_d;
         exec_src_mask_q <= exec_src_mask_d;
         exec_byte_en_q <= exec_byte_en_d;
         exec_range_chk_q <= exec_range_chk_d;
         frame_err_q <= frame_err_d;
      end
   end

   logic [3:0] flags_d;
   logic range_trap_d;

   // Flags follow their conditions exactly; a flag-updating checked op with overflow traps. [RQ5] [RQ6]
   always_comb
   begin
      flags_d = flag_we ? cond_in : flags_q;
      range_trap_d = flag_we && exec_valid_q && exec_range_chk_q && exec_dst_used_q && cond_in[FLAG_V];
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         flags_q <= FLAGS_RESET;
         range_trap_q <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         range_trap_q <= range_trap_d;
      end
   end

   // Checks on the observable behaviour.
   a_issue_needs_hw: assert property (@(posedge mclk) disable iff (!resetn) // [RQ22]
      (consume_q != 2'h0) |-> $past(ic_count) >= consume_q) else $error("issued without all half-words");
   a_load_use_stall: assert property (@(posedge mclk) disable iff (!resetn) // [RQ8]
      (load_pend_q && src_used && src == load_reg_q && !exec_hold) |=> (stall_q && consume_q == 2'h0))
      else $error("load-use not stalled");
   a_pipe_issue: assert property (@(posedge mclk) disable iff (!resetn) // [RQ2]
      (go && !exec_hold) |=> exec_valid_q && exec_len_q == consume_q) else $error("decode not passed to execute");
   a_flag_follow: assert property (@(posedge mclk) disable iff (!resetn) // [RQ5]
      flag_we |=> flags_q == $past(cond_in)) else $error("flag not equal to condition");
   a_shift_mask: assert property (@(posedge mclk) disable iff (!resetn) // [RQ1]
      (go && op == OP_SHIFT) |=> exec_src_mask_q == 32'h0000_001F) else $error("shift mask wrong");
   a_load_target: assert property (@(posedge mclk) disable iff (!resetn) // [RQ21]
      (go && is_load) |=> exec_dst_q == {1'b1, $past(ic_hw0[3:0])} && load_pend_q) else $error("load target wrong");
   a_follow_reg: assert property (@(posedge mclk) disable iff (!resetn) // [RQ10]
      exec_valid_q |-> exec_src_next_q[3:0] == exec_src_q[3:0] + 4'h1 && exec_src_next_q[4] == exec_src_q[4])
      else $error("following register wrong");
   a_bank_select: assert property (@(posedge mclk) disable iff (!resetn) // [RQ13]
      (go && fmt == FMT_RR) |=> exec_src_q == {$past(ic_hw0[SBIT]), $past(ic_hw0[3:0])}) else $error("source bank wrong");
   a_frame_full: assert property (@(posedge mclk) disable iff (!resetn) // [RQ9]
      (go && frame_length_field == 4'h0 && op != OP_FRAME) |=> !frame_err_q) else $error("zero frame not sixteen");
   a_pc_advance: assert property (@(posedge mclk) disable iff (!resetn) // [RQ12]
      go |=> fetch_pc_q == $past(fetch_pc_q) + {29'h0, consume_q, 1'b0}) else $error("pc advance wrong");

   c_three_hw: cover property (@(posedge mclk) disable iff (!resetn) consume_q == 2'h3);
   c_load_stall: cover property (@(posedge mclk) disable iff (!resetn) stall_q ##1 !stall_q);
   c_range_trap: cover property (@(posedge mclk) disable iff (!resetn) range_trap_q);

endmodule

/* File: tb/icache_model.sv */
/*
   Behavioural instruction cache and load pipeline facing the decoder.
   Assumes the bench fills mem by hierarchy and sets avail and lat off the rising edge.
*/
`timescale 1ns/1ps
module icache_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [31:0] fetch_pc,
   input wire logic [1:0] avail,
   input wire logic [1:0] consume,
   input wire logic is_load,
   input wire logic [3:0] lat,
   output logic [15:0] hw0,
   output logic [15:0] hw1,
   output logic [15:0] hw2,
   output logic [1:0] count,
   output logic load_done
);
   logic [15:0] mem [64];
   logic [5:0] a;
   logic [4:0] cnt_q;
   // Half-word addressing wraps modulo 64; words past the valid count are inverted so stale data never helps.
   assign a = fetch_pc[6:1];
   assign hw0 = (avail >= 2'h1) ? mem[a] : ~mem[a];
   assign hw1 = (avail >= 2'h2) ? mem[a + 6'h1] : ~mem[a + 6'h1];
   assign hw2 = (avail == 2'h3) ? mem[a + 6'h2] : ~mem[a + 6'h2];
   assign count = avail;
   // Load data returns lat plus one cycles after the load issues, as slow memory would.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= 5'h00;
         load_done <= 1'b0;
      end
      else
      begin
         load_done <= (cnt_q == 5'h01);
         if (consume != 2'h0 && is_load)
            cnt_q <= {1'b0, lat};
         else if (cnt_q != 5'h00)
            cnt_q <= cnt_q - 5'h01;
      end
   end
endmodule

/* File: tb/tb_insn_decode.sv */
/*
   Self-checking bench for the decoder: runs a short program through the cache model.
   Assumes the opcode map and field layout chosen in the decoder package.
*/
`timescale 1ns/1ps
module tb_insn_decode
   import decode_pkg::*;
();
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic exec_hold = 1'b0, flag_we = 1'b0, stall_seen, done_seen = 1'b0;
   logic [3:0] cond_in = 4'h0, frame_length_field = 4'h0, flags_q;
   logic [1:0] avail = 2'h2, ic_count, consume_q, exec_len_q, exec_dtype_q;
   logic [15:0] ic_hw0, ic_hw1, ic_hw2;
   logic [31:0] fetch_pc_q, exec_operand_q, exec_src_mask_q;
   logic [4:0] exec_src_q, exec_src_next_q, exec_dst_q, exec_dst_next_q, exec_n_q;
   logic [2:0] exec_fmt_q, exec_index_q;
   logic [3:0] exec_byte_en_q;
   logic load_done, stall_q, exec_valid_q, exec_src_used_q, exec_dst_used_q, exec_src_clobbered_q;
   logic exec_same_ok_q, exec_is_load_q, exec_is_store_q, exec_double_q, exec_range_chk_q;
   logic frame_err_q, range_trap_q;
   int failures = 0, checks = 0;
   logic [15:0] prog [0:25] = '{16'h6312, 16'hC123, 16'h4567, 16'h0335, 16'h03FF, 16'h8012, 16'h6312,
      16'h4001, 16'hA000, 16'h1FFF, 16'hA000, 16'hF800, 16'h0001, 16'hE000, 16'hDABC, 16'h1234,
      16'h7101, 16'h0000, 16'h0000, 16'h7102, 16'h0000, 16'h5112, 16'h9237, 16'h2000, 16'h0117, 16'h0335};

   always #20 mclk = ~mclk;

   // Remember that load data came back before the dependent instruction issued.
   always @(posedge mclk)
      if (load_done === 1'b1) done_seen <= 1'b1;

   insn_decode uut (.mclk, .resetn, .ic_hw0, .ic_hw1, .ic_hw2, .ic_count, .exec_hold, .load_done,
      .flag_we, .cond_in, .frame_length_field, .fetch_pc_q, .consume_q, .stall_q, .exec_valid_q,
      .exec_fmt_q, .exec_len_q, .exec_src_q, .exec_src_next_q, .exec_dst_q, .exec_dst_next_q,
      .exec_src_used_q, .exec_dst_used_q, .exec_src_clobbered_q, .exec_same_ok_q, .exec_operand_q,
      .exec_n_q, .exec_dtype_q, .exec_index_q, .exec_is_load_q, .exec_is_store_q, .exec_double_q,
      .exec_src_mask_q, .exec_byte_en_q, .exec_range_chk_q, .frame_err_q, .flags_q, .range_trap_q);

   icache_model cache (.mclk, .resetn, .fetch_pc(fetch_pc_q), .avail, .consume(consume_q),
      .is_load(exec_is_load_q), .lat(4'h4), .hw0(ic_hw0), .hw1(ic_hw1), .hw2(ic_hw2),
      .count(ic_count), .load_done);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Waits a bounded number of cycles for an issue; a stall seen meanwhile is noted.
   task automatic wait_issue(input int bound, input logic [1:0] len);
      int i;
      stall_seen = 1'b0;
      for (i = 0; i < bound; i++)
      begin
         @(negedge mclk);
         if (stall_q === 1'b1) stall_seen = 1'b1;
         if (consume_q !== 2'h0) break;
      end
      if (i == bound)
      begin
         failures++;
         print_verdict();
      end
      else
      begin
         check(consume_q, len);
      end
   endtask

   // Main sequence; the empty cache tail decodes as harmless register moves.
   initial
   begin
      for (int k = 0; k < 64; k++) cache.mem[k] = (k < 26) ? prog[k] : 16'h0000;
      repeat (10) @(posedge mclk);
      check(exec_src_mask_q, 32'hFFFF_FFFF);
      check(fetch_pc_q, PC_RESET);
      check(exec_valid_q, 1'b0);
      @(negedge mclk);
      resetn = 1'b1;
      repeat (3)
      begin
         @(negedge mclk);
         check(consume_q, 2'h0);
      end
      avail = 2'h3;
      wait_issue(4, 2'h3);
      check(exec_operand_q, 32'hC123_4567);
      check(fetch_pc_q, 32'h0000_0006);
      check({exec_valid_q, exec_fmt_q, exec_len_q}, {1'b1, FMT_CONST, 2'h3});
      frame_length_field = 4'h4;
      wait_issue(1, 2'h1);
      check({exec_src_q, exec_dst_q}, {5'h15, 5'h13});
      check({exec_src_next_q, exec_dst_next_q}, {5'h16, 5'h14});
      check({exec_same_ok_q, exec_src_clobbered_q, frame_err_q}, 3'h5);
      check({exec_src_used_q, exec_dst_used_q, exec_fmt_q}, {2'h3, FMT_RR});
      frame_length_field = 4'h0;
      wait_issue(1, 2'h1);
      check({exec_src_next_q, exec_src_clobbered_q, frame_err_q}, {5'h10, 2'h2});
      check(exec_src_mask_q, 32'hFFFF_FFFF);
      wait_issue(1, 2'h1);
      check(exec_src_mask_q, 32'h0000_001F);
      wait_issue(1, 2'h2);
      check(exec_operand_q, 32'hFFFF_C001);
      wait_issue(1, 2'h2);
      check(exec_operand_q, 32'h0000_0FFF);
      check({exec_dtype_q, exec_byte_en_q, exec_is_store_q}, {2'h1, 4'h3, 1'b1});
      wait_issue(1, 2'h3);
      check(exec_operand_q, 32'hF800_0001);
      check({exec_dtype_q, exec_double_q, exec_byte_en_q}, {2'h3, 1'b1, 4'hF});
      wait_issue(1, 2'h3);
      check({exec_index_q, exec_operand_q[28:0]}, {3'h5, 29'h0ABC_1234});
      check(exec_operand_q[31:29], 3'h0);
      wait_issue(1, 2'h3);
      check(exec_n_q, N_LONG);
      check({exec_src_used_q, exec_dst_used_q, exec_fmt_q}, {2'h1, FMT_RIMM});
      wait_issue(1, 2'h2);
      check(exec_n_q, N_ZERO16);
      wait_issue(1, 2'h1);
      check(exec_range_chk_q, 1'b1);
      // Holding execute keeps the checked op in place while both flag outcomes are written.
      exec_hold = 1'b1;
      flag_we = 1'b1;
      cond_in = 4'hA;
      @(negedge mclk);
      check({flags_q, range_trap_q, consume_q}, {4'hA, 1'b1, 2'h0});
      cond_in = 4'h5;
      @(negedge mclk);
      check({flags_q, range_trap_q}, {4'h5, 1'b0});
      exec_hold = 1'b0;
      flag_we = 1'b0;
      wait_issue(1, 2'h2);
      check({exec_is_load_q, exec_src_clobbered_q, exec_dst_q, exec_src_q}, {2'h3, 5'h17, 5'h13});
      wait_issue(12, 2'h1);
      check({stall_seen, done_seen, exec_src_q}, {2'h3, 5'h17});
      wait_issue(1, 2'h1);
      print_verdict();
   end
endmodule
